// file: src/adc_seq_pkg.sv
package adc_seq_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_IRQ_GLOBAL = 8'h18;
  localparam logic [7:0] ADDR_PIN_FUNC = 8'h1C;
  // Control word 0 field positions
  localparam int CH_LSB = 0;
  localparam int ALIGN_BIT = 4;
  localparam int PWR_BIT = 5;
  localparam int BUSY_BIT = 6;
  localparam int START_BIT = 7;
  // Control word 1 field positions
  localparam int DIV_LSB = 0;
  localparam int REF_LSB = 3;
  localparam int SRC_LSB = 5;
  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [3:0] PIN_FUNC_RST = 4'h0;
  // Conversion timing in A/D clock cycles
  localparam logic [3:0] SAMPLE_CYC = 4'd4;
  localparam logic [3:0] CONV_CYC = 4'd10;
  localparam logic [4:0] TOTAL_CYC = 5'd14;
  // Converter word
  localparam int RES_W = 10;
  localparam logic [9:0] FULL_SCALE = 10'h3FF;
  localparam logic [9:0] MSB_MASK = 10'h200;
  // Input source and reference codes
  localparam logic [2:0] SRC_BANDGAP = 3'b001;
  localparam logic [2:0] SRC_LINE_AMP = 3'b010;
  localparam logic [2:0] SRC_GND_LO = 3'b011;
  localparam logic [2:0] SRC_GND_HI = 3'b100;
  localparam logic [1:0] REF_AVDD = 2'b01;
  localparam int NUM_EXT = 4;
  // Conversion sequencer states, Gray along idle-sample-convert
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } conv_state_t;
endpackage

// file: src/adc_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
// A/D clock as a one-cycle enable every 2**div_sel system clocks
module adc_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] div_sel,
  input wire logic restart,
  input wire logic run,
  output logic tick
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] limit;

  // Terminal count from the divide code, zero means every clock
  always_comb begin
    limit = 7'((8'd1 << div_sel) - 8'd1);
    tick = run && (cnt_reg == limit);
    cnt_next = cnt_reg;
    if (restart || !run) begin
      cnt_next = 7'd0;
    end else if (tick) begin
      cnt_next = 7'd0;
    end else begin
      cnt_next = cnt_reg + 7'd1;
    end
  end

  // Counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 7'd0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// file: src/adc_input_route.sv
`timescale 1ns/10ps
`default_nettype none
// Analog switch, reference and pin-override decode, all registered
module adc_input_route
  import adc_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] src_sel,
  input wire logic [3:0] ch_sel,
  input wire logic [1:0] ref_sel,
  input wire logic [3:0] pin_sel,
  output logic [3:0] ext_sw_en,
  output logic sel_bandgap,
  output logic sel_line_amp,
  output logic sel_ground,
  output logic ref_use_avdd,
  output logic [3:0] pin_func_dis,
  output logic [3:0] pin_pullup_dis,
  output logic [3:0] pin_dir_force_in
);
  logic [3:0] sw_next;
  logic [3:0] pin_next;
  logic bg_next;
  logic la_next;
  logic gnd_next;
  logic ref_next;

  // Per channel: switch follows channel code, pin override follows select
  for (genvar i = 0; i < NUM_EXT; i++) begin : g_ch
    assign sw_next[i] = (ch_sel == 4'(i));
    assign pin_next[i] = pin_sel[i];
  end

  // Internal sources; the external switch is not gated here on purpose
  always_comb begin
    bg_next = (src_sel == SRC_BANDGAP);
    la_next = (src_sel == SRC_LINE_AMP);
    gnd_next = (src_sel == SRC_GND_LO) || (src_sel == SRC_GND_HI);
    ref_next = (ref_sel == REF_AVDD);
  end

  // Output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sw_en <= 4'h0;
      sel_bandgap <= 1'b0;
      sel_line_amp <= 1'b0;
      sel_ground <= 1'b0;
      ref_use_avdd <= 1'b0;
      pin_func_dis <= 4'h0;
      pin_pullup_dis <= 4'h0;
      pin_dir_force_in <= 4'h0;
    end else begin
      ext_sw_en <= sw_next;
      sel_bandgap <= bg_next;
      sel_line_amp <= la_next;
      sel_ground <= gnd_next;
      ref_use_avdd <= ref_next;
      pin_func_dis <= pin_next;
      pin_pullup_dis <= pin_next;
      pin_dir_force_in <= pin_next;
    end
  end
endmodule
`default_nettype wire

// file: src/sar_adc_sequencer.sv
// Overview of operation
// - Analog pin drops other functions, pull-up, direction
// - External source codes route channels 0 to 3
// - Channel codes 4 to 15 leave input floating
// - Internal codes pick bandgap, line amp, ground
// - Four sampling plus ten converting A/D cycles
// - Start bit low-high-low launches the conversion
// - Busy high during conversion, results valid after
// - Power enable low switches converter fully off
// - Ten-bit result, full scale 3FF, step ref/1024
// - Conversion uses the selected reference source
// - Align bit picks 6/4 or 2/8 result split
// - Divide code gives system clock over 1 to 128
// - Completion sets flag and raises enabled interrupt
// - Results untouched while power enable is low
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer
  import adc_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_in,
  output logic adc_irq,
  output logic conv_busy,
  output logic adc_power_on,
  output logic sample_en,
  output logic [9:0] dac_code,
  output logic ref_use_avdd,
  output logic [3:0] ext_sw_en,
  output logic sel_bandgap,
  output logic sel_line_amp,
  output logic sel_ground,
  output logic [3:0] pin_func_dis,
  output logic [3:0] pin_pullup_dis,
  output logic [3:0] pin_dir_force_in
);
  import adc_seq_pkg::*;

  // Software-visible state
  logic [7:0] ctrl0_reg; // Channel, align, power, start
  logic [7:0] ctrl0_next;
  logic [7:0] ctrl1_reg; // Divider, reference, source
  logic [7:0] ctrl1_next;
  logic [7:0] res_high_reg; // Upper result byte
  logic [7:0] res_high_next;
  logic [7:0] res_low_reg; // Lower result byte
  logic [7:0] res_low_next;
  logic irq_flag_reg; // Sticky completion flag
  logic irq_flag_next;
  logic irq_en_reg; // Per-source interrupt enable
  logic irq_en_next;
  logic gie_reg; // Global interrupt enable
  logic gie_next;
  logic [3:0] pin_sel_reg; // Pins given to analog input
  logic [3:0] pin_sel_next;

  // Bus answer state
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  // Sequencer state
  conv_state_t state_reg;
  conv_state_t state_next;
  logic [3:0] cnt_reg; // A/D cycles within the phase
  logic [3:0] cnt_next;
  logic [9:0] sar_reg; // Bits decided so far
  logic [9:0] sar_next;

  // Registered pins toward the analog core
  logic irq_reg;
  logic irq_next;
  logic sample_reg;
  logic sample_next;
  logic [9:0] dac_reg;
  logic [9:0] dac_next;
  logic pwr_reg;
  logic pwr_next;
  logic busy_reg; // Busy flag as a flop, mirrors the state register
  logic busy_next;

  // Shared decode terms
  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic busy;
  logic launch;
  logic done;
  logic ad_tick;
  logic [9:0] bit_mask;
  logic [9:0] result;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pready_reg && pwrite;
  assign rd_acc = psel && penable && pready_reg && !pwrite;
  assign busy = (state_reg != ST_IDLE);

  // A/D clock enable; restarted at launch so phases align to it
  adc_clk_div i_adc_clk_div (
    .pclk(pclk),
    .presetn(presetn),
    .div_sel(ctrl1_reg[DIV_LSB +: 3]),
    .restart(launch),
    .run(busy),
    .tick(ad_tick)
  );

  // Switch and pin decode follows the stored selections directly
  adc_input_route i_adc_input_route (
    .pclk(pclk),
    .presetn(presetn),
    .src_sel(ctrl1_reg[SRC_LSB +: 3]),
    .ch_sel(ctrl0_reg[CH_LSB +: 4]),
    .ref_sel(ctrl1_reg[REF_LSB +: 2]),
    .pin_sel(pin_sel_reg),
    .ext_sw_en(ext_sw_en),
    .sel_bandgap(sel_bandgap),
    .sel_line_amp(sel_line_amp),
    .sel_ground(sel_ground),
    .ref_use_avdd(ref_use_avdd),
    .pin_func_dis(pin_func_dis),
    .pin_pullup_dis(pin_pullup_dis),
    .pin_dir_force_in(pin_dir_force_in)
  );

  // Bus decode: answer prepared in setup, writes land in access
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = setup_ph;
    pslverr_next = 1'b0;
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    irq_en_next = irq_en_reg;
    gie_next = gie_reg;
    pin_sel_next = pin_sel_reg;
    hit = 1'b1;
    // Read mux, sampled once in the setup cycle
    if (paddr == ADDR_CTRL0) begin
      prdata_next = {24'h00_0000, ctrl0_reg[START_BIT], busy, ctrl0_reg[5:0]};
    end else if (paddr == ADDR_CTRL1) begin
      prdata_next = {24'h00_0000, ctrl1_reg};
    end else if (paddr == ADDR_RES_HIGH) begin
      prdata_next = {24'h00_0000, res_high_reg};
    end else if (paddr == ADDR_RES_LOW) begin
      prdata_next = {24'h00_0000, res_low_reg};
    end else if (paddr == ADDR_IRQ_STATUS) begin
      prdata_next = {31'h0000_0000, irq_flag_reg};
    end else if (paddr == ADDR_IRQ_MASK) begin
      prdata_next = {31'h0000_0000, irq_en_reg};
    end else if (paddr == ADDR_IRQ_GLOBAL) begin
      prdata_next = {31'h0000_0000, gie_reg};
    end else if (paddr == ADDR_PIN_FUNC) begin
      prdata_next = {28'h000_0000, pin_sel_reg};
    end else begin
      // Unmapped: read zero, flag an error
      prdata_next = 32'h0000_0000;
      hit = 1'b0;
    end
    if (!setup_ph) begin
      prdata_next = prdata_reg;
    end
    if (setup_ph && !hit) begin
      pslverr_next = 1'b1;
    end
    // Writes; busy is read only so its stored bit stays zero
    if (wr_acc) begin
      if (paddr == ADDR_CTRL0) begin
        ctrl0_next = pwdata[7:0];
        ctrl0_next[BUSY_BIT] = 1'b0;
      end else if (paddr == ADDR_CTRL1) begin
        ctrl1_next = pwdata[7:0];
      end else if (paddr == ADDR_IRQ_MASK) begin
        irq_en_next = pwdata[0];
      end else if (paddr == ADDR_IRQ_GLOBAL) begin
        gie_next = pwdata[0];
      end else if (paddr == ADDR_PIN_FUNC) begin
        pin_sel_next = pwdata[3:0];
      end
    end
  end

  // Launch when the start bit is written back low after a high
  assign launch = wr_acc && (paddr == ADDR_CTRL0) && ctrl0_reg[START_BIT]
    && !pwdata[START_BIT] && ctrl0_reg[PWR_BIT] && pwdata[PWR_BIT] && !busy;

  assign bit_mask = MSB_MASK >> cnt_reg;
  assign done = (state_reg == ST_CONVERT) && ad_tick && ctrl0_reg[PWR_BIT]
    && (cnt_reg == CONV_CYC - 4'd1);

  // Successive approximation sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sar_next = sar_reg;
    res_high_next = res_high_reg;
    res_low_next = res_low_reg;
    result = sar_reg | (cmp_in ? bit_mask : 10'h000);
    case (state_reg)
      ST_IDLE: begin
        if (launch) begin
          state_next = ST_SAMPLE;
          cnt_next = 4'd0;
          sar_next = 10'h000;
        end
      end
      ST_SAMPLE: begin
        // Input tracked for four A/D clocks
        if (ad_tick) begin
          if (cnt_reg == SAMPLE_CYC - 4'd1) begin
            state_next = ST_CONVERT;
            cnt_next = 4'd0;
          end else begin
            cnt_next = cnt_reg + 4'd1;
          end
        end
      end
      ST_CONVERT: begin
        // One bit decided per A/D clock, MSB first
        if (ad_tick) begin
          sar_next = result;
          cnt_next = cnt_reg + 4'd1;
          if (done) begin
            state_next = ST_IDLE;
            cnt_next = 4'd0;
            // Both bytes change together with busy falling
            if (ctrl0_reg[ALIGN_BIT]) begin
              res_high_next = {6'h00, result[9:8]};
              res_low_next = result[7:0];
            end else begin
              res_high_next = {2'h0, result[9:4]};
              res_low_next = {4'h0, result[3:0]};
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Power removed mid-conversion aborts; results stay as they are
    if (!ctrl0_reg[PWR_BIT] && busy) begin
      state_next = ST_IDLE;
      cnt_next = 4'd0;
      res_high_next = res_high_reg;
      res_low_next = res_low_reg;
    end
  end

  // Interrupt and analog-facing outputs
  always_comb begin
    irq_flag_next = irq_flag_reg;
    // Read of status clears only what that read returned
    if (rd_acc && (paddr == ADDR_IRQ_STATUS) && prdata_reg[0]) begin
      irq_flag_next = 1'b0;
    end
    // Completion wins over a clear in the same cycle
    if (done) begin
      irq_flag_next = 1'b1;
    end
    irq_next = irq_flag_next && irq_en_next && gie_next;
    pwr_next = ctrl0_next[PWR_BIT];
    sample_next = (state_next == ST_SAMPLE);
    busy_next = (state_next != ST_IDLE);
    // Trial code: decided bits plus the bit under test
    if (state_next == ST_CONVERT) begin
      dac_next = sar_next | (MSB_MASK >> cnt_next);
    end else begin
      dac_next = 10'h000;
    end
  end

  // Register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= CTRL0_RST;
      ctrl1_reg <= CTRL1_RST;
      res_high_reg <= RESULT_RST;
      res_low_reg <= RESULT_RST;
      irq_flag_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      gie_reg <= 1'b0;
      pin_sel_reg <= PIN_FUNC_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      res_high_reg <= res_high_next;
      res_low_reg <= res_low_next;
      irq_flag_reg <= irq_flag_next;
      irq_en_reg <= irq_en_next;
      gie_reg <= gie_next;
      pin_sel_reg <= pin_sel_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Sequencer and analog pin registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'd0;
      sar_reg <= 10'h000;
      irq_reg <= 1'b0;
      sample_reg <= 1'b0;
      dac_reg <= 10'h000;
      pwr_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sar_reg <= sar_next;
      irq_reg <= irq_next;
      sample_reg <= sample_next;
      dac_reg <= dac_next;
      pwr_reg <= pwr_next;
      busy_reg <= busy_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign adc_irq = irq_reg;
  assign conv_busy = busy_reg;
  assign adc_power_on = pwr_reg;
  assign sample_en = sample_reg;
  assign dac_code = dac_reg;
endmodule
`default_nettype wire

// file: test/sar_adc_sequencer_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level watch of the converter sequencer
module sar_adc_sequencer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_irq,
  input wire logic conv_busy,
  input wire logic adc_power_on,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  input wire logic [3:0] ext_sw_en,
  input wire logic sel_bandgap,
  input wire logic sel_line_amp,
  input wire logic sel_ground,
  input wire logic [3:0] pin_func_dis,
  input wire logic [3:0] pin_pullup_dis,
  input wire logic [3:0] pin_dir_force_in
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answers in the first access cycle, for one cycle only
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready && prdata[31:8] == 24'h00_0000)
    else $error("pslverr outside a clean answer");
  a_sample_in_busy: assert property (sample_en |-> conv_busy)
    else $error("sampling outside a conversion");
  // The first trial after sampling tries the top bit alone
  a_first_trial_msb: assert property ($fell(sample_en) && conv_busy && adc_power_on
    |-> dac_code == 10'h200) else $error("first trial code wrong");
  a_idle_code_zero: assert property (!conv_busy && !$past(conv_busy) |-> dac_code == 10'h000)
    else $error("trial code left on while idle");
  // Interrupt rises only at completion or after a register write
  a_irq_cause: assert property ($rose(adc_irq) |-> $fell(conv_busy)
    || $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("interrupt without completion");
  a_power_abort: assert property (!adc_power_on |=> !conv_busy)
    else $error("busy while converter is off");
  a_route_onehot: assert property ($onehot0(ext_sw_en))
    else $error("two channel switches closed");
  a_source_onehot: assert property ($onehot0({sel_bandgap, sel_line_amp, sel_ground}))
    else $error("two internal sources selected");
  a_pin_copies: assert property (pin_func_dis == pin_pullup_dis
    && pin_func_dis == pin_dir_force_in) else $error("pin overrides disagree");
  // Main scenarios reached
  c_done: cover property ($fell(conv_busy));
  c_irq: cover property ($rose(adc_irq));
  c_err: cover property (pslverr);
endmodule
bind sar_adc_sequencer sar_adc_sequencer_monitor i_sar_adc_sequencer_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_irq(adc_irq),
  .conv_busy(conv_busy), .adc_power_on(adc_power_on), .sample_en(sample_en),
  .dac_code(dac_code), .ext_sw_en(ext_sw_en), .sel_bandgap(sel_bandgap),
  .sel_line_amp(sel_line_amp), .sel_ground(sel_ground), .pin_func_dis(pin_func_dis),
  .pin_pullup_dis(pin_pullup_dis), .pin_dir_force_in(pin_dir_force_in));
`default_nettype wire

// file: test/tb_sar_adc_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_sequencer;
  import adc_seq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, cmp_in, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, adc_irq, conv_busy, adc_power_on, sample_en, ref_use_avdd;
  logic sel_bandgap, sel_line_amp, sel_ground;
  logic [9:0] dac_code;
  logic [9:0] target; // Analog level the comparator stands for
  logic [3:0] ext_sw_en, pin_func_dis, pin_pullup_dis, pin_dir_force_in;
  int n_mismatch, checked;

  sar_adc_sequencer i_sar_adc_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_in(cmp_in), .adc_irq(adc_irq), .conv_busy(conv_busy), .adc_power_on(adc_power_on),
    .sample_en(sample_en), .dac_code(dac_code), .ref_use_avdd(ref_use_avdd),
    .ext_sw_en(ext_sw_en), .sel_bandgap(sel_bandgap), .sel_line_amp(sel_line_amp),
    .sel_ground(sel_ground), .pin_func_dis(pin_func_dis), .pin_pullup_dis(pin_pullup_dis),
    .pin_dir_force_in(pin_dir_force_in));

  // Ideal comparator: must follow the trial code within the same tick
  assign cmp_in = (target >= dac_code);

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; an edge first so psel is never driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rdat, exp);
  endtask

  // Full launch, timing count, completion and result split
  task automatic conv(input logic [2:0] dv, input logic al, input logic [9:0] t,
                      input logic en);
    int nb;
    int ns;
    nb = 0;
    ns = 0;
    wr(ADDR_CTRL1, {29'h0, dv});
    wr(ADDR_CTRL0, {24'h00_0000, 2'b00, 1'b1, al, 4'h0});
    wr(ADDR_IRQ_MASK, {31'h0, en});
    target <= t;
    wr(ADDR_CTRL0, {24'h00_0000, 2'b10, 1'b1, al, 4'h0});
    wr(ADDR_CTRL0, {24'h00_0000, 2'b00, 1'b1, al, 4'h0});
    #1;
    while (conv_busy === 1'b1 && nb < 5000) begin
      if (sample_en === 1'b1) ns++;
      @(posedge pclk);
      #1;
      nb++;
    end
    chk("busy cycles", nb, 14 << dv);
    chk("sample cycles", ns, 4 << dv);
    chk("irq", {31'h0, adc_irq}, {31'h0, en});
    chk("power on", {31'h0, adc_power_on}, 32'h0000_0001);
    rd(ADDR_CTRL0, {26'h0, 1'b1, al, 4'h0}, "busy bit");
    rd(ADDR_IRQ_STATUS, 32'h0000_0001, "flag");
    rd(ADDR_IRQ_STATUS, 32'h0000_0000, "flag cleared");
    rd(ADDR_RES_HIGH, al ? 32'(t[9:8]) : 32'(t[9:4]), "result high");
    rd(ADDR_RES_LOW, al ? 32'(t[7:0]) : 32'(t[3:0]), "result low");
    $display("conversion test done, divide code %0d", dv);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog, well beyond the few thousand cycles expected
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end

  // Main sequence
  initial begin
    logic [3:0] ch;
    logic [3:0] pv [3];
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    target = 10'h000;
    n_mismatch = 0;
    checked = 0;
    pv = '{4'h5, 4'hA, 4'h0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only and unmapped places
    rd(ADDR_CTRL0, 32'(CTRL0_RST), "ctrl0 reset");
    rd(ADDR_CTRL1, 32'(CTRL1_RST), "ctrl1 reset");
    rd(8'h20, 32'h0000_0000, "unmapped read");
    chk("slverr", {31'h0, rerr}, 32'h0000_0001);
    wr(ADDR_RES_LOW, 32'h0000_00FF);
    rd(ADDR_RES_LOW, 32'(RESULT_RST), "result read-only");
    $display("register test done");
    // Source, channel and reference decode; channel parked before internal source
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 5; c++) begin
        ch = (s >= 1 && s <= 4) ? 4'(4 + 2 * c) : 4'(c);
        // Internal source: park the channel first; external: source first
        if (s >= 1 && s <= 4) begin
          wr(ADDR_CTRL0, {28'h0, ch});
        end
        wr(ADDR_CTRL1, {24'h00_0000, 3'(s), 2'(c), 3'b000});
        if (s < 1 || s > 4) begin
          wr(ADDR_CTRL0, {28'h0, ch});
        end
        @(posedge pclk);
        #1;
        chk("switch", 32'(ext_sw_en), (ch < 4) ? 32'(1 << ch) : 32'h0000_0000);
        chk("sources", {sel_bandgap, sel_line_amp, sel_ground}, {s == 1, s == 2,
          s == 3 || s == 4});
        chk("reference", {31'h0, ref_use_avdd}, 32'(c == 1));
      end
    end
    $display("routing test done");
    // Pin override copies
    foreach (pv[i]) begin
      wr(ADDR_PIN_FUNC, {28'h0, pv[i]});
      @(posedge pclk);
      #1;
      chk("pin overrides", {pin_func_dis, pin_pullup_dis, pin_dir_force_in},
        {pv[i], pv[i], pv[i]});
    end
    $display("pin test done");
    wr(ADDR_IRQ_GLOBAL, 32'h0000_0001);
    conv(3'd0, 1'b0, 10'h2A5, 1'b1);
    conv(3'd1, 1'b1, 10'h15A, 1'b0);
    conv(3'd2, 1'b1, 10'h0F0, 1'b0);
    // Remaining divide codes, up to the slowest A/D clock
    for (int d = 4; d < 8; d++) begin
      conv(3'(d), 1'(d % 2), 10'(37 * d), 1'(d / 2 % 2));
    end
    conv(3'd3, 1'b0, FULL_SCALE, 1'b1);
    // Power removed mid-conversion: abort, no flag, results kept
    target <= 10'h011;
    wr(ADDR_CTRL0, 32'h0000_00A0);
    wr(ADDR_CTRL0, 32'h0000_0020);
    #1;
    chk("busy after launch", {31'h0, conv_busy}, 32'h0000_0001);
    wr(ADDR_CTRL0, 32'h0000_0000);
    @(posedge pclk);
    #1;
    chk("busy after abort", {31'h0, conv_busy}, 32'h0000_0000);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000, "no flag on abort");
    // Powered off: launch ignored, results kept
    wr(ADDR_CTRL0, 32'h0000_0080);
    target <= 10'h011;
    wr(ADDR_CTRL0, 32'h0000_0000);
    @(posedge pclk);
    #1;
    chk("busy when off", {31'h0, conv_busy}, 32'h0000_0000);
    chk("power output", {31'h0, adc_power_on}, 32'h0000_0000);
    rd(ADDR_RES_HIGH, 32'h0000_003F, "kept high");
    rd(ADDR_RES_LOW, 32'h0000_000F, "kept low");
    $display("power test done");
    print_verdict;
  end
endmodule
`default_nettype wire
